// *** design/dpm_slave.sv ***
// Dual-port management slave: frame decoder and two register banks
`timescale 1ns/1ps
`include "dpm_regs.svh"
module dpm_slave (
  input  wire logic       CLK_I,
  input  wire logic       ARST_N_I,
  input  wire logic [3:0] STRAP_ADDR_I,
  dpm_if.slave            LINK,
  output logic            SYNCED_O,
  output logic            SIMW_O
);
  import dpm_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] mdc_s_q, mdio_s_q;
  logic       mdc_d1_q;
  logic       rise;
  logic       fall;
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mdc_s_q  <= 2'h0;
      mdio_s_q <= 2'h3;
      mdc_d1_q <= 1'b0;
    end else begin
      mdc_s_q  <= {mdc_s_q[0], LINK.mdc};
      mdio_s_q <= {mdio_s_q[0], LINK.mdio};
      mdc_d1_q <= mdc_s_q[1];
    end
  end
  assign rise = mdc_s_q[1] & ~mdc_d1_q;
  assign fall = ~mdc_s_q[1] & mdc_d1_q;
  wire bit_in = mdio_s_q[1];

  // Strap passes two flops, then is held from the second cycle after reset
  logic [3:0] strap_s_q;
  logic [3:0] strap_q;
  logic       strap_vld_q;
  logic       strap_done_q;
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      strap_s_q    <= 4'h0;
      strap_vld_q  <= 1'b0;
      strap_q      <= 4'h0;
      strap_done_q <= 1'b0;
    end else begin
      strap_s_q   <= STRAP_ADDR_I;
      strap_vld_q <= 1'b1;
      if (strap_vld_q && !strap_done_q) begin
        strap_q      <= strap_s_q;
        strap_done_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register banks
  // ----------------------------------------------------------------
  dpm_word_t bank_a [`DPM_NREG];
  dpm_word_t bank_b [`DPM_NREG];

  typedef enum logic [6:0] {
    ST_HUNT  = 7'h01,
    ST_IDLE  = 7'h02,
    ST_START = 7'h04,
    ST_HDR   = 7'h08,
    ST_TA    = 7'h10,
    ST_DATA  = 7'h20,
    ST_SKIP  = 7'h40
  } dpm_state_t;

  dpm_state_t  st_q, st_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [11:0] hdr_q, hdr_d;
  logic [15:0] sh_q, sh_d;
  logic        oe_q, oe_d, dout_q, dout_d;
  logic        we;
  logic        sync_q, sync_d;

  wire [1:0]  op   = hdr_q[11:10];
  wire [4:0]  padr = hdr_q[9:5];
  wire [4:0]  radr = hdr_q[4:0];
  wire        hit_a = (padr == {strap_q, 1'b0});
  wire        hit_b = (padr == {strap_q, 1'b1});
  wire        simw  = bank_a[`DPM_BYP_ADDR][`DPM_BYP_SIMW];

  function automatic dpm_word_t rd_word(input logic pb, input dpm_addr_t a);
    dpm_word_t w;
    w = pb ? bank_b[a] : bank_a[a];
    if (a == `DPM_STAT_ADDR) w[`DPM_STAT_PRESUP] = 1'b1;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Frame decoder
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    hdr_d  = hdr_q;
    sh_d   = sh_q;
    oe_d   = oe_q;
    dout_d = dout_q;
    sync_d = sync_q;
    we     = 1'b0;
    if (rise) begin
      case (st_q)
        ST_HUNT: begin
          // Count consecutive ones; a zero restarts the run
          cnt_d = bit_in ? ((cnt_q == `DPM_PRE_LEN) ? cnt_q : cnt_q + 6'h01) : 6'h00;
          if (cnt_d == `DPM_PRE_LEN) begin
            st_d   = ST_IDLE;
            sync_d = 1'b1;
          end
        end
        ST_IDLE: begin
          if (!bit_in) st_d = ST_START;
        end
        ST_START: begin
          if (bit_in) begin
            st_d  = ST_HDR;
            cnt_d = 6'h00;
          end else begin
            st_d = ST_HUNT;
            sync_d = 1'b0;
            cnt_d = 6'h00;
          end
        end
        ST_HDR: begin
          hdr_d = {hdr_q[10:0], bit_in};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h01 && {hdr_q[0], bit_in} != `DPM_OP_READ
              && {hdr_q[0], bit_in} != `DPM_OP_WRITE) begin
            st_d = ST_HUNT;
            sync_d = 1'b0;
            cnt_d = 6'h00;
          end else if (cnt_q == 6'h0b) begin
            st_d  = ST_TA;
            cnt_d = 6'h00;
          end
        end
        ST_TA: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h00) begin
            // Write: station must drive a one here
            if (op == `DPM_OP_WRITE && !bit_in) begin
              st_d = ST_HUNT;
              sync_d = 1'b0;
              cnt_d = 6'h00;
            end
          end else begin
            if (op == `DPM_OP_WRITE && bit_in) begin
              st_d = ST_HUNT;
              sync_d = 1'b0;
              cnt_d = 6'h00;
            end else begin
              st_d  = (hit_a || hit_b || op == `DPM_OP_WRITE) ? ST_DATA : ST_SKIP;
              cnt_d = 6'h00;
            end
          end
        end
        ST_DATA, ST_SKIP: begin
          sh_d  = (op == `DPM_OP_WRITE) ? {sh_q[14:0], bit_in} : sh_q;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h0f) begin
            st_d = ST_IDLE;
            we   = (op == `DPM_OP_WRITE) && (st_q == ST_DATA);
          end
        end
        default: st_d = ST_HUNT;
      endcase
    end
    // Read drive changes on the falling edge so it is stable at the station's rising edge
    if (fall) begin
      if (st_q == ST_TA && cnt_q == 6'h01 && op == `DPM_OP_READ && (hit_a || hit_b)) begin
        oe_d   = 1'b1;
        dout_d = 1'b0;
        sh_d   = rd_word(hit_b, radr);
      end else if (st_q == ST_DATA && op == `DPM_OP_READ) begin
        dout_d = sh_q[15];
        sh_d   = {sh_q[14:0], 1'b0};
      end else begin
        oe_d   = 1'b0;
        dout_d = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_q   <= ST_HUNT;
      cnt_q  <= 6'h00;
      hdr_q  <= 12'h000;
      sh_q   <= 16'h0000;
      oe_q   <= 1'b0;
      dout_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      hdr_q  <= hdr_d;
      sh_q   <= sh_d;
      oe_q   <= oe_d;
      dout_q <= dout_d;
      sync_q <= sync_d;
    end
  end

  // ----------------------------------------------------------------
  // Register write; shift holds all but the last bit at we
  // ----------------------------------------------------------------
  wire [15:0] wdata = {sh_q[14:0], bit_in};
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < `DPM_NREG; i++) begin
        bank_a[i] <= 16'h0000;
        bank_b[i] <= 16'h0000;
      end
    end else if (we) begin
      if (hit_a) bank_a[radr] <= wdata;
      if (hit_b || (hit_a && simw)) bank_b[radr] <= wdata;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SYNCED_O <= 1'b0;
      SIMW_O   <= 1'b0;
    end else begin
      SYNCED_O <= sync_q;
      SIMW_O   <= simw;
    end
  end

  assign LINK.slv_mdio_o  = dout_q;
  assign LINK.slv_mdio_oe = oe_q;
endmodule

// *** design/dpm_regs.svh ***
// Constants for the dual-port serial management block
//
// Behaviour
// - Each port holds thirty-two 16-bit registers.
// - Station sends 32 one-bits before first frame; station here sends them only when PRE_I is high.
// - Preamble may be idle-high line with clocks.
// - Slave ignores frames until preamble seen.
// - Reset or bad field drops sync; needs 32 ones.
// - Frame starts with zero then one.
// - Fields: start, op, port, reg, turnaround, data.
// - Read: release first turnaround, drive zero, data.
// - Write: station drives one, zero, then data.
// - Status register bit 6 reads one.
// - Station may drop preamble once all support it.
// - One idle bit between frames suffices.
// - Bypass register bit 15 enables simultaneous write.
// - Port A writes then also update Port B.
// - Reads return only the addressed port.
// - Port A address LSB zero, Port B one.
`ifndef DPM_REGS_SVH
`define DPM_REGS_SVH
`define DPM_PRE_LEN       6'h20
`define DPM_DATA_W        16
`define DPM_NREG          32
`define DPM_STAT_ADDR     5'h01
`define DPM_STAT_PRESUP   6
`define DPM_BYP_ADDR      5'h17
`define DPM_BYP_SIMW      15
`define DPM_OP_READ       2'h2
`define DPM_OP_WRITE      2'h1
`define DPM_MDC_HALF      8'h04
`define DPM_RD_FIRST      7'h31
`define DPM_RD_END        7'h41
`endif

// *** design/dpm_pkg.sv ***
// Types shared by both ends of the management link
package dpm_pkg;
  typedef logic [15:0] dpm_word_t;
  typedef logic [4:0]  dpm_addr_t;
endpackage

// *** design/dpm_if.sv ***
// Management link between station and dual-port slave
`timescale 1ns/1ps
interface dpm_if;
  logic mdc;
  logic sta_mdio_o;
  logic sta_mdio_oe;
  logic slv_mdio_o;
  logic slv_mdio_oe;
  wire  mdio;
  // Pull-up: line idles high when nobody drives
  assign mdio = sta_mdio_oe ? sta_mdio_o : (slv_mdio_oe ? slv_mdio_o : 1'b1);
  modport slave (input mdc, input mdio, output slv_mdio_o, output slv_mdio_oe);
  modport station (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio);
endinterface

// *** design/dpm_station.sv ***
// Station end: issues management frames over the link
`timescale 1ns/1ps
`include "dpm_regs.svh"
module dpm_station (
  input  wire logic            CLK_I,
  input  wire logic            ARST_N_I,
  input  wire logic            REQ_I,
  input  wire logic            WRITE_I,
  input  wire logic            PRE_I,
  input  wire dpm_pkg::dpm_addr_t PADR_I,
  input  wire dpm_pkg::dpm_addr_t RADR_I,
  input  wire dpm_pkg::dpm_word_t WDATA_I,
  dpm_if.station               LINK,
  output logic                 BUSY_O,
  output logic                 DONE_O,
  output dpm_pkg::dpm_word_t   RDATA_O
);
  import dpm_pkg::*;

  // ----------------------------------------------------------------
  // Clock divider and sampling
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  logic       mdc_q;
  logic [1:0] din_s_q;
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div_q   <= 8'h00;
      mdc_q   <= 1'b0;
      din_s_q <= 2'h3;
    end else begin
      div_q   <= (div_q == `DPM_MDC_HALF - 8'h01) ? 8'h00 : div_q + 8'h01;
      if (div_q == `DPM_MDC_HALF - 8'h01) mdc_q <= ~mdc_q;
      din_s_q <= {din_s_q[0], LINK.mdio};
    end
  end
  wire tick_fall = (div_q == `DPM_MDC_HALF - 8'h01) && mdc_q;
  wire tick_rise = (div_q == `DPM_MDC_HALF - 8'h01) && !mdc_q;

  // Frame: 32 preamble, 32 frame and 32 idle bits, shifted out MSB first and stopping after the 17th idle bit
  logic [95:0] fr_q, fr_d;
  logic [6:0]  n_q, n_d;
  logic        wr_q, wr_d, act_q, act_d, oe_q, oe_d, do_q, do_d, dn_q, dn_d;
  logic [15:0] rd_q, rd_d;

  always_comb begin
    fr_d  = fr_q;
    n_d   = n_q;
    wr_d  = wr_q;
    act_d = act_q;
    oe_d  = oe_q;
    do_d  = do_q;
    rd_d  = rd_q;
    dn_d  = 1'b0;
    if (!act_q && REQ_I) begin
      act_d = 1'b1;
      wr_d  = WRITE_I;
      // 32 ones when preamble requested, else one idle bit
      fr_d  = {32'hffffffff, 2'h1, WRITE_I ? `DPM_OP_WRITE : `DPM_OP_READ,
               PADR_I, RADR_I, WRITE_I ? 2'h2 : 2'h3, WRITE_I ? WDATA_I : 16'hffff,
               32'hffffffff};
      n_d   = PRE_I ? 7'h00 : 7'h1f;
    end else if (act_q && tick_fall) begin
      // Read: release line from turnaround on; write: drive through data and 16 idle bits
      oe_d = wr_q ? (n_q < 7'h50) : (n_q < 7'h2e);
      do_d = fr_q[7'h5f - n_q];
    end else if (act_q && tick_rise) begin
      // Read bits lag one mdc period: the slave's edge detect plus our two sync
      // flops take longer than half a period, so bit 15 is caught one rise later
      if (!wr_q && n_q >= `DPM_RD_FIRST && n_q < `DPM_RD_END) begin
        rd_d = {rd_q[14:0], din_s_q[1]};
      end
      n_d = n_q + 7'h01;
      if (n_q == 7'h50) begin
        act_d = 1'b0;
        dn_d  = 1'b1;
        oe_d  = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      fr_q  <= '0;
      n_q   <= 7'h00;
      wr_q  <= 1'b0;
      act_q <= 1'b0;
      oe_q  <= 1'b0;
      do_q  <= 1'b1;
      rd_q  <= 16'h0000;
      dn_q  <= 1'b0;
    end else begin
      fr_q  <= fr_d;
      n_q   <= n_d;
      wr_q  <= wr_d;
      act_q <= act_d;
      oe_q  <= oe_d;
      do_q  <= do_d;
      rd_q  <= rd_d;
      dn_q  <= dn_d;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      BUSY_O  <= 1'b0;
      DONE_O  <= 1'b0;
      RDATA_O <= 16'h0000;
    end else begin
      BUSY_O  <= act_d;
      DONE_O  <= dn_d;
      RDATA_O <= rd_d;
    end
  end

  assign LINK.mdc         = mdc_q;
  assign LINK.sta_mdio_o  = do_q;
  assign LINK.sta_mdio_oe = oe_q;
endmodule

// *** tb/dpm_assertions.sv ***
// Wire-level checks on the management link
`timescale 1ns/1ps
module dpm_assertions (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic mdc,
  input wire logic sta_mdio_o,
  input wire logic sta_mdio_oe,
  input wire logic slv_mdio_o,
  input wire logic slv_mdio_oe,
  input wire logic mdio
);
  logic       mdc_q;
  logic [4:0] rise_cnt_q;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // Counts mdc rises while the slave drives, to pin the read field length
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mdc_q      <= 1'b0;
      rise_cnt_q <= 5'h00;
    end else begin
      mdc_q      <= mdc;
      rise_cnt_q <= !slv_mdio_oe ? 5'h00 : rise_cnt_q + 5'(mdc & !mdc_q);
    end
  end
  sequence s_quiet;
    !slv_mdio_oe [*6];
  endsequence
  sequence s_idle;
    mdio [*6];
  endsequence
  a_no_contention: assert property (!(sta_mdio_oe && slv_mdio_oe))
    else $error("both ends drive the line");
  a_ta_zero: assert property ($rose(slv_mdio_oe) |-> !slv_mdio_o)
    else $error("slave turnaround bit not zero");
  a_drive_len: assert property ($fell(slv_mdio_oe) |-> rise_cnt_q == 5'h11)
    else $error("slave drove a wrong number of bits");
  a_ta_release: assert property ($fell(sta_mdio_oe) |-> s_quiet)
    else $error("slave drove first turnaround bit");
  a_idle_gap: assert property ($fell(slv_mdio_oe) |-> s_idle)
    else $error("no idle bit after read");
  a_mdc_high: assert property ($rose(mdc) |-> mdc [*4])
    else $error("mdc high phase too short");
  a_sta_edge: assert property (sta_mdio_oe && $changed(sta_mdio_o) |-> !mdc)
    else $error("station data changed while mdc high");
  a_slv_edge: assert property (slv_mdio_oe && $changed(slv_mdio_o) |-> !mdc)
    else $error("slave data changed while mdc high");
endmodule

// *** tb/tb.sv ***
// Self-checking bench: station and slave joined over the link
`timescale 1ns/1ps
module tb;
  import dpm_pkg::*;
  logic        clk, arst_n, req, wr, pre, busy, done, synced, simw, synced2;
  logic [3:0]  strap;
  dpm_addr_t   padr, radr, pa, pb;
  dpm_word_t   wdata, rdata, va, ex_b[32];
  logic [16:0] notes[$];
  logic [16:0] nt;
  int          n_mismatch, n_checks;
  dpm_if link();
  dpm_if link2();
  dpm_station u_dpm_station (.CLK_I(clk), .ARST_N_I(arst_n), .REQ_I(req), .WRITE_I(wr),
    .PRE_I(pre), .PADR_I(padr), .RADR_I(radr), .WDATA_I(wdata), .LINK(link.station),
    .BUSY_O(busy), .DONE_O(done), .RDATA_O(rdata));
  dpm_slave u_dpm_slave (.CLK_I(clk), .ARST_N_I(arst_n), .STRAP_ADDR_I(strap),
    .LINK(link.slave), .SYNCED_O(synced), .SIMW_O(simw));
  // Second slave faces a bench driver that breaks the opcode on purpose
  dpm_slave u_dpm_slave_2 (.CLK_I(clk), .ARST_N_I(arst_n), .STRAP_ADDR_I(strap),
    .LINK(link2.slave), .SYNCED_O(synced2), .SIMW_O());
  dpm_assertions u_dpm_assertions (.CLK_I(clk), .ARST_N_I(arst_n), .mdc(link.mdc),
    .sta_mdio_o(link.sta_mdio_o), .sta_mdio_oe(link.sta_mdio_oe), .slv_mdio_o(link.slv_mdio_o),
    .slv_mdio_oe(link.slv_mdio_oe), .mdio(link.mdio));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic miss(input string m);
    n_mismatch++;
    $display("mismatch %0t %s", $time, m);
  endtask
  task automatic chk_word(input dpm_word_t e, input dpm_word_t g);
    n_checks++;
    if (g !== e) miss($sformatf("word %h expected %h", g, e));
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) miss("flag");
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && n_checks > 0 && notes.size() == 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, p, input dpm_addr_t ad, r, input dpm_word_t d, e);
    int k;
    k = 0;
    notes.push_back({!w, e});
    @(posedge clk);
    {req, wr, pre, padr, radr, wdata} <= {1'b1, w, p, ad, r, d};
    @(posedge clk);
    req <= 1'b0;
    #1;
    while (busy !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) begin
      miss("timeout");
      complete_run;
    end
  endtask
  // Bench plays station on the second link, one bit per mdc period
  task automatic drv2(input logic b);
    {link2.sta_mdio_o, link2.sta_mdio_oe, link2.mdc} <= {b, 2'b10};
    repeat (4) @(posedge clk);
    link2.mdc <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) miss("unexpected done");
      else begin
        nt = notes.pop_front();
        if (nt[16]) chk_word(nt[15:0], rdata);
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {arst_n, req, wr, pre, padr, radr, wdata} = '0;
    {link2.mdc, link2.sta_mdio_o, link2.sta_mdio_oe} = 3'b010;
    void'($urandom(33));
    strap = 4'($urandom);
    pa = {strap, 1'b0};
    pb = {strap, 1'b1};
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk_bit(synced, 1'b0);
    xfer(0, 0, pa, 5'h01, 16'h0000, 16'hffff);
    // Released line plus running mdc forms a preamble by itself
    chk_bit(synced, 1'b1);
    xfer(0, 1, pa, 5'h01, 16'h0000, 16'h0040);
    chk_bit(synced, 1'b1);
    va = 16'($urandom);
    xfer(1, 0, pa, 5'h05, va, 16'h0000);
    xfer(1, 0, {~strap, 1'b0}, 5'h05, ~va, 16'h0000);
    xfer(0, 0, pa, 5'h05, 16'h0000, va);
    xfer(0, 0, pb, 5'h05, 16'h0000, 16'h0000);
    xfer(1, 0, pa, 5'h17, 16'h8000 | va, 16'h0000);
    chk_bit(simw, 1'b1);
    xfer(1, 0, pa, 5'h09, ~va, 16'h0000);
    xfer(0, 0, pb, 5'h09, 16'h0000, ~va);
    xfer(0, 0, pb, 5'h17, 16'h0000, 16'h0000);
    for (int i = 0; i < 32; i++) begin
      ex_b[i] = 16'($urandom) | (i == 1 ? 16'h0040 : 16'h0000);
      xfer(1, 0, pb, 5'(i), ex_b[i], 16'h0000);
    end
    for (int i = 0; i < 32; i++) xfer(0, 0, pb, 5'(i), 16'h0000, ex_b[i]);
    repeat (32) drv2(1'b1);
    // Slave sees the last rise through two flops and registers its flag twice
    repeat (2) @(posedge clk);
    chk_bit(synced2, 1'b1);
    drv2(1'b0);
    drv2(1'b1);
    drv2(1'b1);
    drv2(1'b1);
    link2.sta_mdio_oe <= 1'b0;
    repeat (2) @(posedge clk);
    chk_bit(synced2, 1'b0);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk_bit(simw, 1'b0);
    xfer(0, 0, pa, 5'h17, 16'h0000, 16'hffff);
    repeat (20) @(posedge clk);
    complete_run;
  end
endmodule
